// ---- bench/bus_ctrl_model.sv ----
// behavioural two-wire bus controller that drives the target port
// assumes pull-ups on both lines; the bench calls its tasks in turn
`timescale 1ns/10ps
module bus_ctrl_model (
  // pacing clock
  input wire logic clock,
  // bus lines
  input wire logic sdaLine,
  output logic sclLine,
  output logic sdaDrv
);
  // ==========================================================
  // pacing
  // a quarter of a 400kHz scl period in system clocks
  localparam int QUARTER = 125;

  initial begin
    sclLine = 1'h1;
    sdaDrv = 1'h1;
  end

  task automatic waitQ();
    repeat (QUARTER) @(posedge clock);
    #1;
  endtask

  // ==========================================================
  // conditions
  // also serves as repeated start; leaves scl low
  task automatic startCond();
    sdaDrv = 1'h1;
    waitQ();
    sclLine = 1'h1;
    waitQ();
    sdaDrv = 1'h0;
    waitQ();
    sclLine = 1'h0;
  endtask

  // stop in its own scl high, never in the start's one
  task automatic stopCond();
    waitQ();
    sdaDrv = 1'h0;
    waitQ();
    sclLine = 1'h1;
    waitQ();
    sdaDrv = 1'h1;
    waitQ();
    waitQ();
  endtask

  // ==========================================================
  // bits and bytes
  // data changes only while scl is low
  task automatic bitCycle(input logic b, output logic s);
    waitQ();
    sdaDrv = b;
    waitQ();
    sclLine = 1'h1;
    waitQ();
    s = sdaLine;
    waitQ();
    sclLine = 1'h0;
  endtask

  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitCycle(b[i], s);
    end
    bitCycle(1'h1, ack);
  endtask

  task automatic recvByte(input logic ackBit, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitCycle(1'h1, d[i]);
    end
    bitCycle(ackBit, s);
  endtask

  // breaks the controller's own rule on purpose to probe the target's guard
  task automatic startStopHigh();
    sdaDrv = 1'h1;
    waitQ();
    sclLine = 1'h1;
    waitQ();
    sdaDrv = 1'h0;
    waitQ();
    sdaDrv = 1'h1;
    waitQ();
    sclLine = 1'h0;
  endtask
endmodule

// ---- bench/tb_top.sv ----
// self-checking bench for the two-wire target port
// assumes the controller model and a register file read as ptr xor 5A
`timescale 1ns/10ps
module tb_top;
  // ==========================================================
  // stimulus and wires
  localparam int CEILING = 90000;
  logic clock = 1'h0;
  logic rst_n = 1'h0;
  logic extClk = 1'h0;
  logic extRun = 1'h1;
  logic [7:0] intSources = 8'h00;
  logic [7:0] intMask = 8'h00;
  logic [7:0] regRdData;
  logic [7:0] regPtr;
  logic sclLine, sdaDrv, sdaLine, sdaOut, sdaOe_n, intOut, intOe_n;
  logic busActive, timingTick, extClockActive;
  sensor_i2c_pkg::reg_req_s regReq;
  logic [15:0] wrLog[$];
  logic [7:0] rdLog[$];
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  int tickCount = 0;

  always #2.5 clock = ~clock;
  initial begin
    #1.3;
    forever begin
      #7.5;
      if (extRun) begin
        extClk = ~extClk;
      end
    end
  end

  // open-drain wire: either party may pull low
  assign sdaLine = sdaDrv & (sdaOe_n | sdaOut);
  assign regRdData = regPtr ^ 8'h5A;

  sensor_i2c_target i_sensor_i2c_target (
    .clock(clock), .rst_n(rst_n), .externalTimingClockIn(extClk),
    .sclIn(sclLine), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n),
    .intOut(intOut), .intOe_n(intOe_n), .intSources(intSources), .intMask(intMask),
    .regReq(regReq), .regPtr(regPtr), .regRdData(regRdData),
    .busActive(busActive), .timingTick(timingTick), .extClockActive(extClockActive)
  );

  bus_ctrl_model i_bus_ctrl_model (
    .clock(clock), .sdaLine(sdaLine), .sclLine(sclLine), .sdaDrv(sdaDrv)
  );

  always @(posedge clock) begin
    cycles++;
    if (regReq.wr) begin
      wrLog.push_back({regReq.addr, regReq.wdata});
    end
    if (regReq.rd) begin
      rdLog.push_back(regReq.addr);
    end
    if (timingTick) begin
      tickCount++;
    end
    if (cycles == CEILING) begin
      miscompares++;
      stop_test();
    end
  end

  // ==========================================================
  // helpers
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic sendChk(input logic [7:0] b, input logic e);
    logic a;
    i_bus_ctrl_model.sendByte(b, a);
    check("ack", 16'(a), 16'(e));
  endtask

  task automatic stop_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic test_write();
    int n;
    n = wrLog.size();
    i_bus_ctrl_model.startCond();
    check("busActive", 16'(busActive), 16'h1);
    sendChk(8'hC0, 1'h0);
    sendChk(8'h06, 1'h0);
    sendChk(8'h11, 1'h0);
    sendChk(8'h22, 1'h0);
    sendChk(8'h33, 1'h0);
    i_bus_ctrl_model.stopCond();
    check("busActive", 16'(busActive), 16'h0);
    check("writes", 16'(wrLog.size() - n), 16'h3);
    check("write 1", wrLog[n], 16'h0611);
    check("write 2", wrLog[n+1], 16'h0722);
    check("write 3", wrLog[n+2], 16'h0733);
    $display("write test done");
  endtask

  task automatic test_sr_read();
    logic [7:0] d;
    int n;
    n = rdLog.size();
    i_bus_ctrl_model.startCond();
    sendChk(8'hC0, 1'h0);
    sendChk(8'h05, 1'h0);
    i_bus_ctrl_model.startCond();
    check("busActive", 16'(busActive), 16'h1);
    sendChk(8'hC1, 1'h0);
    i_bus_ctrl_model.recvByte(1'h0, d);
    check("read 1", 16'(d), 16'h5F);
    i_bus_ctrl_model.recvByte(1'h1, d);
    check("read 2", 16'(d), 16'h5C);
    check("reads", 16'(rdLog.size() - n), 16'h2);
    check("read addr 1", 16'(rdLog[n]), 16'h05);
    check("read addr 2", 16'(rdLog[n+1]), 16'h06);
    i_bus_ctrl_model.stopCond();
    check("regPtr", 16'(regPtr), 16'h7);
    $display("repeated start read test done");
  endtask

  // stop lands in mid data byte; nothing may be written
  task automatic test_early_stop();
    int n;
    logic s;
    n = wrLog.size();
    i_bus_ctrl_model.startCond();
    sendChk(8'hC0, 1'h0);
    sendChk(8'h02, 1'h0);
    for (int i = 0; i < 3; i++) begin
      i_bus_ctrl_model.bitCycle(i[0], s);
    end
    i_bus_ctrl_model.stopCond();
    check("busActive", 16'(busActive), 16'h0);
    check("sdaOe_n", 16'(sdaOe_n), 16'h1);
    check("writes", 16'(wrLog.size() - n), 16'h0);
    $display("early stop test done");
  endtask

  task automatic test_fresh_read();
    logic [7:0] d;
    i_bus_ctrl_model.startCond();
    sendChk(8'hC1, 1'h0);
    i_bus_ctrl_model.recvByte(1'h1, d);
    check("read 0", 16'(d), 16'h5A);
    i_bus_ctrl_model.stopCond();
    check("sdaOe_n", 16'(sdaOe_n), 16'h1);
    $display("fresh read test done");
  endtask

  task automatic test_wrong_addr();
    int n;
    n = wrLog.size();
    i_bus_ctrl_model.startCond();
    sendChk(8'hC2, 1'h1);
    sendChk(8'h01, 1'h1);
    i_bus_ctrl_model.stopCond();
    check("writes", 16'(wrLog.size() - n), 16'h0);
    $display("foreign address test done");
  endtask

  // a stop inside the start's own high pulse must be ignored
  task automatic test_start_stop_pulse();
    i_bus_ctrl_model.startStopHigh();
    check("busActive", 16'(busActive), 16'h1);
    i_bus_ctrl_model.stopCond();
    check("busActive", 16'(busActive), 16'h0);
    $display("start stop pulse test done");
  endtask

  task automatic test_int();
    logic [15:0] pat [5] = '{16'hFF00, 16'h0FF0, 16'h8181, 16'h3C03, 16'h0101};
    logic expOe_n [5] = '{1'h1, 1'h1, 1'h0, 1'h1, 1'h0};
    foreach (pat[i]) begin
      @(posedge clock);
      #1;
      intSources = pat[i][15:8];
      intMask = pat[i][7:0];
      repeat (3) @(posedge clock);
      #1;
      check("intOe_n", 16'(intOe_n), 16'(expOe_n[i]));
    end
    check("intOut", 16'(intOut), 16'h0);
    $display("interrupt test done");
  endtask

  // absent timing clock falls back to the internal divide by 16
  task automatic test_timing();
    check("extActive", 16'(extClockActive), 16'h1);
    extRun = 1'h0;
    repeat (200) @(posedge clock);
    #1;
    check("extActive", 16'(extClockActive), 16'h0);
    tickCount = 0;
    repeat (64) @(posedge clock);
    #1;
    check("ticks", 16'(tickCount), 16'h4);
    $display("timing clock test done");
  endtask

  initial begin
    repeat (16) @(posedge clock);
    #1;
    check("sdaOe_n", 16'(sdaOe_n), 16'h1);
    check("busActive", 16'(busActive), 16'h0);
    rst_n = 1'h1;
    test_write();
    test_sr_read();
    test_early_stop();
    test_fresh_read();
    test_wrong_addr();
    test_start_stop_pulse();
    test_int();
    test_timing();
    stop_test();
  end
endmodule

// ---- hw/sensor_i2c_target.sv ----
// two-wire serial target port of the optical sensing front end
// assumes the register file sits on clock and answers regRdData from regPtr
// in the same cycle; the timing clock may be absent
`timescale 1ns/10ps

// Contract
// R1: controller makes every scl pulse and begins every transfer.
// R2: scl up to 400kHz supported; controller never faster.
// R3: write is address+W, one index byte, then data bytes.
// R4: every write opens with START or Sr, closes with STOP.
// R5: eight bits per byte, then one acknowledge clock.
// R6: read is address+R, then nine clocks per byte.
// R7: read data shifted out on sda with controller's clocks.
// R8: controller acks each read byte except last, then NACK and STOP.
// R9: sda is input plus open-drain pull-low only.
// R10: scl is input only, never driven or stretched.
// R11: one data bit per scl cycle either way.
// R12: driver holds sda stable while scl high.
// R13: sda change while scl high is a control condition.
// R14: idle bus leaves both lines released high.
// R15: sda falling with scl high is START, begins transfer.
// R16: sda rising with scl high is STOP, frees bus.
// R17: repeated START keeps transaction, takes new address, no idle.
// R18: STOP recognised anywhere except in START's own scl high.
// R19: controller never puts STOP in START's scl high.
// R20: interrupt output active low, open drain, programmable sources.
// R21: optional timing clock; internal timing when it is absent.
// R22: answer only seven-bit address 0x60, bytes 0xC0 and 0xC1.
// R23: ack by holding sda low through the whole ninth pulse.
// R24: pointer advances after each data byte, except at FIFO data.
// R25: START then read address resets pointer to 0x00.
// R26: early STOP drops partial byte, releases sda, goes idle.
module sensor_i2c_target (
  // clocks and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic externalTimingClockIn,
  // serial bus pins
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe_n,
  // interrupt pin
  output logic intOut,
  output logic intOe_n,
  input wire logic [7:0] intSources,
  input wire logic [7:0] intMask,
  // register file side
  output sensor_i2c_pkg::reg_req_s regReq,
  output logic [7:0] regPtr,
  input wire logic [7:0] regRdData,
  // status and timing
  output logic busActive,
  output logic timingTick,
  output logic extClockActive
);

  // ==========================================================
  // pin synchronisers
  logic sclS;
  logic sdaS;
  logic sclP_q;
  logic sdaP_q;

  // 200 MHz oversampling leaves hundreds of samples per scl bit; see R2
  sync_2ff uSclSync (
    .clock(clock),
    .rst_n(rst_n),
    .asyncIn(sclIn),
    .syncOut(sclS)
  );

  sync_2ff uSdaSync (
    .clock(clock),
    .rst_n(rst_n),
    .asyncIn(sdaIn),
    .syncOut(sdaS)
  );

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sclP_q <= 1'b1;
      sdaP_q <= 1'b1;
    end else begin
      sclP_q <= sclS;
      sdaP_q <= sdaS;
    end
  end

  // ==========================================================
  // line events
  logic startHigh_q;
  wire sclRise = sclS & ~sclP_q;
  wire sclFall = ~sclS & sclP_q;
  wire sclHeld = sclS & sclP_q;
  // sda moving under a high scl is never data; see R13
  wire startRaw = sclHeld & sdaP_q & ~sdaS; // see R15
  wire stopRaw = sclHeld & ~sdaP_q & sdaS; // see R16
  // a stop inside the start's own high pulse is not honoured; see R18
  wire stopSeen = stopRaw & ~startHigh_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      startHigh_q <= 1'b0;
    end else if (startRaw) begin
      startHigh_q <= 1'b1;
    end else if (!sclS) begin
      startHigh_q <= 1'b0;
    end
  end

  // ==========================================================
  // byte engine state
  sensor_i2c_pkg::bus_state_e state_q, state_d;
  sensor_i2c_pkg::byte_phase_e phase_q, phase_d;
  sensor_i2c_pkg::reg_req_s req_q, req_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] rxShift_q, rxShift_d;
  logic [7:0] txShift_q, txShift_d;
  logic [7:0] ptr_q, ptr_d;
  logic isRead_q, isRead_d;
  logic fresh_q, fresh_d;
  logic hostAck_q, hostAck_d;
  logic sdaLow_q, sdaLow_d;

  wire addrHit = rxShift_q[7:1] == sensor_i2c_pkg::DEV_ADDR7; // see R22
  wire atFifo = ptr_q == sensor_i2c_pkg::FIFO_DATA_IDX;
  // fifo data index is a window, so it never advances; see R24
  wire [7:0] ptrNext = atFifo ? ptr_q : ptr_q + 8'h01;
  wire rxByteDone = sclFall && cnt_q == sensor_i2c_pkg::BYTE_BITS; // see R5
  // next read byte is loaded on the fall that ends an ack slot
  wire loadTx = sclFall &&
    ((state_q == sensor_i2c_pkg::ST_ACK && isRead_q) ||
     (state_q == sensor_i2c_pkg::ST_TXACK && hostAck_q));

  // ==========================================================
  // next state
  always_comb begin
    state_d = state_q;
    phase_d = phase_q;
    cnt_d = cnt_q;
    rxShift_d = rxShift_q;
    txShift_d = txShift_q;
    ptr_d = ptr_q;
    isRead_d = isRead_q;
    fresh_d = fresh_q;
    hostAck_d = hostAck_q;
    sdaLow_d = sdaLow_q;
    req_d = '0;
    if (stopSeen) begin
      // partial byte is dropped and the line let go; see R26
      state_d = sensor_i2c_pkg::ST_IDLE;
      cnt_d = 4'h0;
      sdaLow_d = 1'b0;
    end else if (startRaw) begin
      // repeated start keeps the pointer and skips idle; see R17
      state_d = sensor_i2c_pkg::ST_RX;
      phase_d = sensor_i2c_pkg::PH_ADDR;
      cnt_d = 4'h0;
      sdaLow_d = 1'b0;
      fresh_d = state_q == sensor_i2c_pkg::ST_IDLE;
    end else if (loadTx) begin
      // first bit goes out on the same fall; see R7
      state_d = sensor_i2c_pkg::ST_TX;
      txShift_d = regRdData;
      sdaLow_d = ~regRdData[7];
      req_d.rd = 1'b1;
      req_d.addr = ptr_q;
      ptr_d = ptrNext; // see R24
      cnt_d = 4'h0;
    end else begin
      case (state_q)
        sensor_i2c_pkg::ST_RX: begin
          if (sclRise) begin
            // one bit per rising edge; see R11
            rxShift_d = {rxShift_q[6:0], sdaS};
            cnt_d = cnt_q + 4'h1;
          end else if (rxByteDone) begin
            cnt_d = 4'h0;
            state_d = sensor_i2c_pkg::ST_ACK;
            sdaLow_d = 1'b1; // see R23
            case (phase_q)
              sensor_i2c_pkg::PH_ADDR: begin
                isRead_d = rxShift_q[0];
                if (!addrHit) begin
                  state_d = sensor_i2c_pkg::ST_SKIP;
                  sdaLow_d = 1'b0;
                end else if (rxShift_q[0] && fresh_q) begin
                  ptr_d = sensor_i2c_pkg::PTR_RESET; // see R25
                end
              end
              sensor_i2c_pkg::PH_INDEX: begin
                ptr_d = rxShift_q;
              end
              default: begin
                req_d.wr = 1'b1;
                req_d.addr = ptr_q;
                req_d.wdata = rxShift_q;
                ptr_d = ptrNext; // see R24
              end
            endcase
          end
        end
        sensor_i2c_pkg::ST_ACK: begin
          if (sclFall) begin
            sdaLow_d = 1'b0;
            state_d = sensor_i2c_pkg::ST_RX;
            phase_d = (phase_q == sensor_i2c_pkg::PH_ADDR) ?
              sensor_i2c_pkg::PH_INDEX : sensor_i2c_pkg::PH_DATA;
          end
        end
        sensor_i2c_pkg::ST_TX: begin
          if (sclFall) begin
            if (cnt_q == sensor_i2c_pkg::TX_LAST_BIT) begin
              // release for the controller's ack slot
              sdaLow_d = 1'b0;
              state_d = sensor_i2c_pkg::ST_TXACK;
            end else begin
              txShift_d = {txShift_q[6:0], 1'b0};
              sdaLow_d = ~txShift_q[6]; // see R7
              cnt_d = cnt_q + 4'h1;
            end
          end
        end
        sensor_i2c_pkg::ST_TXACK: begin
          if (sclRise) begin
            hostAck_d = ~sdaS;
          end else if (sclFall) begin
            // nack ends the read; wait for stop or start
            state_d = sensor_i2c_pkg::ST_SKIP;
          end
        end
        sensor_i2c_pkg::ST_IDLE, sensor_i2c_pkg::ST_SKIP: begin
          sdaLow_d = 1'b0;
        end
        default: begin
          state_d = sensor_i2c_pkg::ST_IDLE;
          sdaLow_d = 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // byte engine registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= sensor_i2c_pkg::ST_IDLE;
      phase_q <= sensor_i2c_pkg::PH_ADDR;
      cnt_q <= 4'h0;
      rxShift_q <= 8'h00;
      txShift_q <= 8'h00;
      ptr_q <= sensor_i2c_pkg::PTR_RESET;
      isRead_q <= 1'b0;
      fresh_q <= 1'b0;
      hostAck_q <= 1'b0;
      sdaLow_q <= 1'b0;
      req_q <= '0;
    end else begin
      state_q <= state_d;
      phase_q <= phase_d;
      cnt_q <= cnt_d;
      rxShift_q <= rxShift_d;
      txShift_q <= txShift_d;
      ptr_q <= ptr_d;
      isRead_q <= isRead_d;
      fresh_q <= fresh_d;
      hostAck_q <= hostAck_d;
      sdaLow_q <= sdaLow_d;
      req_q <= req_d;
    end
  end

  // sda is only ever pulled low, idle released; see R9, R14
  // no scl output exists at all; see R10
  assign sdaOut = 1'b0;
  assign sdaOe_n = ~sdaLow_q;
  assign regReq = req_q;
  assign regPtr = ptr_q;
  assign busActive = state_q != sensor_i2c_pkg::ST_IDLE;

  // ==========================================================
  // interrupt pin
  logic intOe_n_q;

  // sources are gated by the mask; see R20
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      intOe_n_q <= 1'b1;
    end else begin
      intOe_n_q <= ~|(intSources & intMask);
    end
  end

  assign intOut = 1'b0;
  assign intOe_n = intOe_n_q;

  // ==========================================================
  // timing clock domain
  // a toggle every few timing clocks keeps the crossing slow
  logic [2:0] fDiv_q;
  logic fTog_q;

  always_ff @(posedge externalTimingClockIn or negedge rst_n) begin
    if (!rst_n) begin
      fDiv_q <= 3'h0;
      // matches the synchroniser's reset level, so no false edge after reset
      fTog_q <= 1'b1;
    end else if (fDiv_q == sensor_i2c_pkg::TICK_TOGGLE_DIV - 3'h1) begin
      fDiv_q <= 3'h0;
      fTog_q <= ~fTog_q;
    end else begin
      fDiv_q <= fDiv_q + 3'h1;
    end
  end

  logic togS;
  logic togP_q;
  logic [7:0] watch_q;
  logic [7:0] intDiv_q;
  logic tick_q;

  sync_2ff uTogSync (
    .clock(clock),
    .rst_n(rst_n),
    .asyncIn(fTog_q),
    .syncOut(togS)
  );

  wire extEdge = togS ^ togP_q;
  wire extAlive = watch_q != 8'h00;
  wire intWrap = intDiv_q == sensor_i2c_pkg::INT_TICK_DIV - 8'h01;

  // a floating timing pin stops toggling, so the watchdog falls back; see R21
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      togP_q <= 1'b1;
      watch_q <= 8'h00;
      intDiv_q <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      togP_q <= togS;
      watch_q <= extEdge ? sensor_i2c_pkg::EXT_WATCH :
        (extAlive ? watch_q - 8'h01 : 8'h00);
      intDiv_q <= intWrap ? 8'h00 : intDiv_q + 8'h01;
      tick_q <= extAlive ? extEdge : intWrap;
    end
  end

  assign timingTick = tick_q;
  assign extClockActive = extAlive;

  // ==========================================================
  // checks
  localparam int TICK_MIN = 1;
  localparam int TICK_MAX = 16;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // the pin is pulled only in an ack slot or while a read bit is out
  a_sda_open_drain: assert property ( // see R9
    !sdaOe_n |-> sdaOut == 1'b0 &&
      (state_q == sensor_i2c_pkg::ST_ACK || state_q == sensor_i2c_pkg::ST_TX))
    else $error("sda pulled outside ack or data");
  a_stop_to_idle: assert property ( // see R16
    stopSeen |=> state_q == sensor_i2c_pkg::ST_IDLE && sdaOe_n)
    else $error("stop did not free the bus");
  a_start_to_addr: assert property ( // see R15
    startRaw |=> state_q == sensor_i2c_pkg::ST_RX &&
      phase_q == sensor_i2c_pkg::PH_ADDR && cnt_q == 4'h0)
    else $error("start did not open an address byte");
  a_ack_held_low: assert property ( // see R23
    state_q == sensor_i2c_pkg::ST_ACK && !sclFall |-> !sdaOe_n)
    else $error("ack slot not held low");
  a_ptr_on_read: assert property ( // see R25
    state_q == sensor_i2c_pkg::ST_RX && phase_q == sensor_i2c_pkg::PH_ADDR &&
      rxByteDone && !stopSeen && !startRaw && addrHit && rxShift_q[0] && fresh_q
      |=> ptr_q == sensor_i2c_pkg::PTR_RESET ##1 !req_q.rd)
    else $error("pointer not cleared before read");
  a_ptr_advance: assert property ( // see R24
    req_q.wr || req_q.rd |-> ptr_q == (req_q.addr == sensor_i2c_pkg::FIFO_DATA_IDX ?
      req_q.addr : req_q.addr + 8'h01) || $past(stopSeen) || $past(startRaw))
    else $error("pointer step wrong");
  a_tx_stable_high: assert property ( // see R12
    sclHeld && state_q == sensor_i2c_pkg::ST_TX && $past(state_q) == state_q
      |-> $stable(sdaOe_n))
    else $error("sda moved while scl high");
  a_sr_not_idle: assert property ( // see R17
    startRaw && busActive |=> busActive && !fresh_q)
    else $error("repeated start went idle");
  a_stop_in_start: assert property ( // see R18
    stopRaw && startHigh_q |=> busActive)
    else $error("stop in start pulse honoured");
  a_int_follow: assert property ( // see R20
    |(intSources & intMask) |=> !intOe_n)
    else $error("interrupt not asserted");
  a_internal_tick: assert property ( // see R21
    !extAlive && !$past(extAlive) |-> ##[TICK_MIN:TICK_MAX] (timingTick || extAlive))
    else $error("no internal timing tick");

endmodule

// ---- hw/sync_2ff.sv ----
// two flip-flop level synchroniser
// assumes the input is asynchronous to clock
`timescale 1ns/10ps
module sync_2ff (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // level
  input wire logic asyncIn,
  output logic syncOut
);

  logic meta_q;

  // reset value high: bus lines rest released
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b1;
      syncOut <= 1'b1;
    end else begin
      meta_q <= asyncIn;
      syncOut <= meta_q;
    end
  end

endmodule

// ---- shared/sensor_i2c_pkg.sv ----
// constants, enumerations and carrier types for the two-wire target port
// assumes a 200 MHz system clock and a free or absent timing clock
package sensor_i2c_pkg;

  // ==========================================================
  // bus addressing
  localparam logic [6:0] DEV_ADDR7 = 7'h60;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] FIFO_DATA_IDX = 8'h07;

  // ==========================================================
  // byte framing
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] TX_LAST_BIT = 4'h7;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SCL_MAX_KHZ = 400;
  // shortest legal scl period in system clocks, rounded up
  localparam int SCL_MIN_PERIOD_CYC =
    (1000000000 / SCL_MAX_KHZ + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [2:0] TICK_TOGGLE_DIV = 3'h4;
  localparam logic [7:0] EXT_WATCH = 8'h40;
  localparam logic [7:0] INT_TICK_DIV = 8'h10;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RX = 3'h1,
    ST_ACK = 3'h2,
    ST_TX = 3'h3,
    ST_TXACK = 3'h4,
    ST_SKIP = 3'h5
  } bus_state_e;

  typedef enum logic [1:0] {
    PH_ADDR = 2'h0,
    PH_INDEX = 2'h1,
    PH_DATA = 2'h2
  } byte_phase_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

endpackage
